//--- logic/sec_err_defs.svh
/*
  Offsets, field positions and reset values of the secondary error
  severity tail and the capabilities and control register.
  Assumes inclusion by bare name from design files.
*/
`ifndef SEC_ERR_DEFS_SVH
`define SEC_ERR_DEFS_SVH

// extended configuration byte offsets
`define SEV_REG_OFFSET        12'h134
`define CAPS_CTRL_OFFSET      12'h138
`define UNCOR_STATUS_OFFSET   12'h12C

// severity register field positions
`define SEV_SPLIT_TABORT_BIT  0
`define SEV_SPLIT_MABORT_BIT  1
`define SEV_RECV_TABORT_BIT   2
`define SEV_RECV_MABORT_BIT   3
`define SEV_RSVD_BIT          4
`define SEV_UNEXP_SPLIT_BIT   5
`define SEV_SPLIT_MSG_BIT     6
`define SEV_HELD_MSB          6

// reset values
`define SEV_RESET             7'h40
`define CAPS_CTRL_RESET       32'h0000_0000
`define PTR_RESET             5'h00

// capabilities and control field layout
`define PTR_MSB               4

`endif

//--- logic/sec_err_pkg.sv
/*
  Types shared by the severity and first error pointer logic.
  Assumes nothing of its surroundings.
*/
package sec_err_pkg;

  typedef logic [4:0] err_ptr_t;

  // kind of error message raised toward the upstream port
  typedef enum logic [1:0] {
    MSG_NONE     = 2'b00,
    MSG_NONFATAL = 2'b01,
    MSG_FATAL    = 2'b10
  } msg_kind_t;

endpackage

//--- logic/first_error_tracker.sv
/*
  First error pointer tracker: latches the bit index of the earliest
  unmasked error class and holds it while that status bit stays set.
  Assumes status bits set on the same edge that the detect pulse is seen.
*/
`timescale 1ns/10ps
`include "sec_err_defs.svh"

module first_error_tracker
  import sec_err_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] detect,
  input  wire logic [WIDTH-1:0] status,
  input  wire logic [WIDTH-1:0] mask,
  output err_ptr_t              pointer
);

  logic             held;
  logic             next_held;
  err_ptr_t         next_pointer;
  logic [WIDTH-1:0] fresh;

  // lowest index wins when several classes fire in one cycle
  function automatic err_ptr_t lowest_set(input logic [WIDTH-1:0] v);
    err_ptr_t r;
    r = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = err_ptr_t'(i);
      end
    end
    return r;
  endfunction

  // capture only into an empty log; release once the pointed bit clears
  always_comb begin
    fresh        = detect & ~mask;
    next_pointer = pointer;
    next_held    = held;
    if (held && !status[pointer]) begin
      next_held = 1'b0;
    end
    if (!next_held && (fresh != '0) && ((status & ~mask) == '0)) begin
      next_pointer = lowest_set(fresh);
      next_held    = 1'b1;
    end
  end

  // pointer survives hot reset; only the combined sticky reset clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer <= `PTR_RESET;
      held    <= 1'b0;
    end else begin
      pointer <= next_pointer;
      held    <= next_held;
    end
  end

endmodule

//--- logic/secondary_error_severity_pointer.sv
/*
  Secondary error severity tail, capabilities and control register with
  first error pointer, and fatal or non-fatal message selection for
  received master and target aborts.
  Assumes a configuration port with one-cycle request strobes, synchronous
  error detect pulses, and resets already free of metastability.
*/
`timescale 1ns/10ps
`include "sec_err_defs.svh"

// Overview of operation
// - A received master or target abort raises a fatal message when its severity bit is 1, else a non-fatal one.
// - Both abort severity bits come out of reset at 0, so these errors default to non-fatal.
// - The four split related severity bits are plain storage and never change how an error is reported.
// - The reserved bit between the split and abort severity bits always reads 0.
// - The capabilities and control register sits at offset 138h, is read-only and resets to all zeros.
// - Bits 31 to 5 of that register are reserved and read as zero.
// - Bits 4 to 0 hold the index, within the status register at 12Ch, of the earliest detected unmasked error class.
// - Only hardware detection updates the pointer and software writes to it are ignored.
// - Severity bits and pointer are cleared only by fundamental, global or power-on reset, never by hot reset.
// - State that is neither sticky nor flagged, here the message and read outputs, is also cleared by hot reset.
module secondary_error_severity_pointer
  import sec_err_pkg::*;
#(
  parameter int STATUS_WIDTH = 32
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    fundamental_reset_n,
  input  wire logic                    global_reset_n,
  input  wire logic                    hot_reset,
  input  wire logic                    cfg_rd,
  input  wire logic                    cfg_wr,
  input  wire logic [11:0]             cfg_addr,
  input  wire logic [3:0]              cfg_be,
  input  wire logic [31:0]             cfg_wdata,
  output logic [31:0]                  cfg_rdata,
  output logic                         cfg_ack,
  input  wire logic                    recv_mabort_det,
  input  wire logic                    recv_tabort_det,
  input  wire logic [STATUS_WIDTH-1:0] err_detect,
  input  wire logic [STATUS_WIDTH-1:0] uncor_status,
  input  wire logic [STATUS_WIDTH-1:0] uncor_mask,
  output logic                         err_msg_valid,
  output logic                         err_msg_fatal,
  output err_ptr_t                     first_error_pointer
);

  // flagged bits share one reset; hot reset is deliberately absent here
  logic sticky_rst_n;
  assign sticky_rst_n = rst_n & fundamental_reset_n & global_reset_n;

  // severity storage, bits 6:0 of the severity register
  logic recv_mabort_fatal_sel;
  logic recv_tabort_fatal_sel;
  logic split_msg_data_err_sel;
  logic unexpected_split_err_sel;
  logic split_mabort_err_sel;
  logic split_tabort_err_sel;
  logic next_recv_mabort_fatal_sel;
  logic next_recv_tabort_fatal_sel;
  logic next_split_msg_data_err_sel;
  logic next_unexpected_split_err_sel;
  logic next_split_mabort_err_sel;
  logic next_split_tabort_err_sel;

  logic [31:0] next_cfg_rdata;
  logic        next_cfg_ack;
  logic        next_err_msg_valid;
  logic        next_err_msg_fatal;
  msg_kind_t   msg_kind;
  logic        sev_hit;
  logic        caps_hit;

  // reset pattern held at its own width so each field takes one bit of it
  localparam logic [6:0] SEV_RESET_WORD = `SEV_RESET;

  assign sev_hit  = (cfg_addr == `SEV_REG_OFFSET);
  assign caps_hit = (cfg_addr == `CAPS_CTRL_OFFSET);

  // severity writes take byte lane 0 only; all fields live there
  always_comb begin
    next_recv_mabort_fatal_sel    = recv_mabort_fatal_sel;
    next_recv_tabort_fatal_sel    = recv_tabort_fatal_sel;
    next_split_msg_data_err_sel   = split_msg_data_err_sel;
    next_unexpected_split_err_sel = unexpected_split_err_sel;
    next_split_mabort_err_sel     = split_mabort_err_sel;
    next_split_tabort_err_sel     = split_tabort_err_sel;
    if (cfg_wr && sev_hit && cfg_be[0]) begin
      next_recv_mabort_fatal_sel    = cfg_wdata[`SEV_RECV_MABORT_BIT];
      next_recv_tabort_fatal_sel    = cfg_wdata[`SEV_RECV_TABORT_BIT];
      next_split_msg_data_err_sel   = cfg_wdata[`SEV_SPLIT_MSG_BIT];
      next_unexpected_split_err_sel = cfg_wdata[`SEV_UNEXP_SPLIT_BIT];
      next_split_mabort_err_sel     = cfg_wdata[`SEV_SPLIT_MABORT_BIT];
      next_split_tabort_err_sel     = cfg_wdata[`SEV_SPLIT_TABORT_BIT];
    end
  end

  // sticky severity flops: hot reset leaves them alone
  always_ff @(posedge clk or negedge sticky_rst_n) begin
    if (!sticky_rst_n) begin
      recv_mabort_fatal_sel    <= SEV_RESET_WORD[`SEV_RECV_MABORT_BIT];
      recv_tabort_fatal_sel    <= SEV_RESET_WORD[`SEV_RECV_TABORT_BIT];
      split_msg_data_err_sel   <= SEV_RESET_WORD[`SEV_SPLIT_MSG_BIT];
      unexpected_split_err_sel <= SEV_RESET_WORD[`SEV_UNEXP_SPLIT_BIT];
      split_mabort_err_sel     <= SEV_RESET_WORD[`SEV_SPLIT_MABORT_BIT];
      split_tabort_err_sel     <= SEV_RESET_WORD[`SEV_SPLIT_TABORT_BIT];
    end else begin
      recv_mabort_fatal_sel    <= next_recv_mabort_fatal_sel;
      recv_tabort_fatal_sel    <= next_recv_tabort_fatal_sel;
      split_msg_data_err_sel   <= next_split_msg_data_err_sel;
      unexpected_split_err_sel <= next_unexpected_split_err_sel;
      split_mabort_err_sel     <= next_split_mabort_err_sel;
      split_tabort_err_sel     <= next_split_tabort_err_sel;
    end
  end

  // pointer tracker; it sees no write path at all
  first_error_tracker #(
    .WIDTH   (STATUS_WIDTH)
  ) u_tracker (
    .clk     (clk),
    .rst_n   (sticky_rst_n),
    .detect  (err_detect),
    .status  (uncor_status),
    .mask    (uncor_mask),
    .pointer (first_error_pointer)
  );

  // read mux; unmapped offsets and reserved bits answer zero
  function automatic logic [31:0] read_word(input logic s_hit, input logic c_hit);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (s_hit) begin
      w[`SEV_RECV_MABORT_BIT]  = recv_mabort_fatal_sel;
      w[`SEV_RECV_TABORT_BIT]  = recv_tabort_fatal_sel;
      w[`SEV_SPLIT_MSG_BIT]    = split_msg_data_err_sel;
      w[`SEV_UNEXP_SPLIT_BIT]  = unexpected_split_err_sel;
      w[`SEV_SPLIT_MABORT_BIT] = split_mabort_err_sel;
      w[`SEV_SPLIT_TABORT_BIT] = split_tabort_err_sel;
      w[`SEV_RSVD_BIT]         = 1'b0;
    end else if (c_hit) begin
      w = `CAPS_CTRL_RESET;
      w[`PTR_MSB:0] = first_error_pointer;
    end
    return w;
  endfunction

  // abort severity picks the message kind; split bits never enter here
  always_comb begin
    msg_kind = MSG_NONE;
    if ((recv_mabort_det && recv_mabort_fatal_sel) || (recv_tabort_det && recv_tabort_fatal_sel)) begin
      msg_kind = MSG_FATAL;
    end else if (recv_mabort_det || recv_tabort_det) begin
      msg_kind = MSG_NONFATAL;
    end
    next_err_msg_valid = (msg_kind != MSG_NONE);
    next_err_msg_fatal = (msg_kind == MSG_FATAL);
    next_cfg_ack       = cfg_rd | cfg_wr;
    next_cfg_rdata     = cfg_rd ? read_word(sev_hit, caps_hit) : 32'h0000_0000;
    if (hot_reset) begin
      next_err_msg_valid = 1'b0;
      next_err_msg_fatal = 1'b0;
      next_cfg_ack       = 1'b0;
      next_cfg_rdata     = 32'h0000_0000;
    end
  end

  // non-sticky outputs: combined sticky reset plus synchronous hot reset
  always_ff @(posedge clk or negedge sticky_rst_n) begin
    if (!sticky_rst_n) begin
      err_msg_valid <= 1'b0;
      err_msg_fatal <= 1'b0;
      cfg_ack       <= 1'b0;
      cfg_rdata     <= 32'h0000_0000;
    end else begin
      err_msg_valid <= next_err_msg_valid;
      err_msg_fatal <= next_err_msg_fatal;
      cfg_ack       <= next_cfg_ack;
      cfg_rdata     <= next_cfg_rdata;
    end
  end

endmodule

//--- test/sev_ptr_monitor.sv
/* checker on the severity and pointer block ports
   assumes a bind to the top module */
`timescale 1ns/10ps
`include "sec_err_defs.svh"
module sev_ptr_monitor
  import sec_err_pkg::*;
#(parameter int STATUS_WIDTH = 32) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    fundamental_reset_n,
  input wire logic                    global_reset_n,
  input wire logic                    hot_reset,
  input wire logic                    cfg_rd,
  input wire logic                    cfg_wr,
  input wire logic [11:0]             cfg_addr,
  input wire logic [31:0]             cfg_rdata,
  input wire logic                    cfg_ack,
  input wire logic                    recv_mabort_det,
  input wire logic                    recv_tabort_det,
  input wire logic [STATUS_WIDTH-1:0] err_detect,
  input wire logic [STATUS_WIDTH-1:0] uncor_status,
  input wire logic [STATUS_WIDTH-1:0] uncor_mask,
  input wire logic                    err_msg_valid,
  input wire logic                    err_msg_fatal,
  input wire err_ptr_t                first_error_pointer
);
  err_ptr_t exp_ptr;
  // lowest unmasked detect index, registered on the same edge as the pointer
  always_ff @(posedge clk) begin
    exp_ptr <= '0;
    for (int i = STATUS_WIDTH - 1; i >= 0; i--) begin
      if (err_detect[i] && !uncor_mask[i]) begin
        exp_ptr <= i[4:0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!(rst_n && fundamental_reset_n && global_reset_n));
  sequence caps_rd_s;
    cfg_rd && !hot_reset && cfg_addr == `CAPS_CTRL_OFFSET;
  endsequence
  sequence sev_rd_s;
    cfg_rd && !hot_reset && cfg_addr == `SEV_REG_OFFSET;
  endsequence
  ack_one_a: assert property ((cfg_rd || cfg_wr) && !hot_reset |=> cfg_ack) else $error("no ack");
  caps_read_a: assert property (caps_rd_s |=> cfg_rdata == {27'h000_0000, $past(first_error_pointer)})
    else $error("bad caps read");
  rsvd_read_a: assert property (sev_rd_s |=> cfg_rdata[31:7] == 25'h000_0000 && !cfg_rdata[4])
    else $error("reserved bit set");
  msg_raise_a: assert property ((recv_mabort_det || recv_tabort_det) && !hot_reset |=> err_msg_valid)
    else $error("message missing");
  msg_cause_a: assert property (!(recv_mabort_det || recv_tabort_det) || hot_reset |=> !err_msg_valid)
    else $error("message without cause");
  ptr_capture_a: assert property ((err_detect & ~uncor_mask) != '0 && (uncor_status & ~uncor_mask) == '0
    && !uncor_status[first_error_pointer] && !hot_reset |=> first_error_pointer == exp_ptr) else $error("bad capture");
  ptr_hold_a: assert property (uncor_status[first_error_pointer] |=> $stable(first_error_pointer))
    else $error("pointer moved");
  ptr_quiet_a: assert property ((err_detect & ~uncor_mask) == '0 |=> $stable(first_error_pointer))
    else $error("pointer changed idle");
  hot_clear_a: assert property (hot_reset |=> !cfg_ack && !err_msg_valid && !err_msg_fatal && cfg_rdata == '0)
    else $error("hot reset left outputs");
endmodule
bind secondary_error_severity_pointer sev_ptr_monitor #(.STATUS_WIDTH(STATUS_WIDTH)) i_mon (.*);

//--- test/uncor_status_model.sv
/* status register standing at the far side
   assumes detect pulses and a clear mask from the bench */
`timescale 1ns/10ps
module uncor_status_model #(parameter int WIDTH = 32) (
  input  wire logic [WIDTH-1:0] detect,
  input  wire logic [WIDTH-1:0] clr,
  input  wire logic             clk,
  input  wire logic             rst_n,
  output logic      [WIDTH-1:0] status
);
  logic [WIDTH-1:0] next_status;
  // set on the detect edge as the pointer expects; clear wins
  always_comb begin
    next_status = (status | detect) & ~clr;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end
endmodule

//--- test/tb_secondary_error_severity_pointer.sv
/* bench for the severity and pointer block
   assumes the status model drives the status inputs */
`timescale 1ns/10ps
`include "sec_err_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_secondary_error_severity_pointer;
  logic        clk, rst_n, fundamental_reset_n, global_reset_n, hot_reset, cfg_rd, cfg_wr, cfg_ack;
  logic        recv_mabort_det, recv_tabort_det, err_msg_valid, err_msg_fatal;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd_q, err_detect, uncor_status, uncor_mask, clr;
  logic [4:0]  first_error_pointer;
  logic [75:0] rows [4];
  int          n_errors, n_checks;
  secondary_error_severity_pointer i_dut (.*);
  uncor_status_model i_stat (.clk(clk), .rst_n(rst_n), .detect(err_detect), .clr(clr), .status(uncor_status));
  // free running clock
  always #50 clk = ~clk;
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} = {!wr, wr, a, d};
    @(negedge clk);
    {cfg_rd, cfg_wr} = 2'b00;
    rd_q = cfg_rdata;
    `CHK("ack", 1'b1, cfg_ack)
  endtask
  task automatic abort(input logic m, input logic t, input logic f);
    @(negedge clk);
    {recv_mabort_det, recv_tabort_det} = {m, t};
    @(negedge clk);
    {recv_mabort_det, recv_tabort_det} = 2'b00;
    `CHK("valid", 1'b1, err_msg_valid)
    `CHK("fatal", f, err_msg_fatal)
  endtask
  task automatic det(input logic [31:0] d);
    @(negedge clk);
    err_detect = d;
    @(negedge clk);
    err_detect = '0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the real run
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    {clk, rst_n, fundamental_reset_n, global_reset_n, hot_reset, cfg_rd, cfg_wr} = '0;
    {recv_mabort_det, recv_tabort_det, cfg_addr, cfg_wdata, err_detect, uncor_mask, clr} = '0;
    cfg_be = 4'h1;
    rows = '{{`SEV_REG_OFFSET, 32'hFFFF_FFFF, 32'h0000_006F}, {`SEV_REG_OFFSET, 32'h0000_0010, 32'h0000_0000},
             {`CAPS_CTRL_OFFSET, 32'hFFFF_FFFF, 32'h0000_0000}, {12'h200, 32'hFFFF_FFFF, 32'h0000_0000}};
    repeat (6) @(negedge clk);
    {rst_n, fundamental_reset_n, global_reset_n} = 3'b111;
    acc(0, `SEV_REG_OFFSET, '0);
    `CHK("sev reset", 32'h0000_0040, rd_q)
    acc(0, `CAPS_CTRL_OFFSET, '0);
    `CHK("caps reset", 32'h0000_0000, rd_q)
    // write, then read back
    for (int r = 0; r < 4; r++) begin
      acc(1, rows[r][75:64], rows[r][63:32]);
      acc(0, rows[r][75:64], '0);
      `CHK("readback", rows[r][31:0], rd_q)
    end
    // split bits always set, they must not sway the severity
    for (int i = 0; i < 4; i++) begin
      acc(1, `SEV_REG_OFFSET, 32'h0000_0063 | 32'(i << 2));
      abort(1, 0, i[1]);
      abort(0, 1, i[0]);
      abort(1, 1, i != 0);
    end
    uncor_mask = 32'h0000_0008;
    det(32'h0000_0288);
    acc(0, `CAPS_CTRL_OFFSET, '0);
    `CHK("ptr read", 32'h0000_0007, rd_q)
    det(32'h0000_0004);
    acc(1, `CAPS_CTRL_OFFSET, 32'hFFFF_FFFF);
    `CHK("ptr held", 5'h07, first_error_pointer)
    @(negedge clk);
    clr = 32'hFFFF_FFFF;
    @(negedge clk);
    clr = '0;
    det(32'h0000_0400);
    `CHK("ptr recapture", 5'h0A, first_error_pointer)
    @(negedge clk);
    {hot_reset, cfg_rd, recv_mabort_det} = 3'b111;
    @(negedge clk);
    {hot_reset, cfg_rd, recv_mabort_det} = 3'b000;
    `CHK("hot ack", 1'b0, cfg_ack)
    `CHK("hot msg", 1'b0, err_msg_valid)
    `CHK("hot ptr", 5'h0A, first_error_pointer)
    acc(0, `SEV_REG_OFFSET, '0);
    `CHK("hot sev", 32'h0000_006F, rd_q)
    // a severity write without byte lane 0 must leave the bits alone
    cfg_be = 4'h0;
    acc(1, `SEV_REG_OFFSET, 32'h0000_0000);
    cfg_be = 4'h1;
    acc(0, `SEV_REG_OFFSET, '0);
    `CHK("no lane0", 32'h0000_006F, rd_q)
    for (int k = 0; k < 2; k++) begin
      acc(1, `SEV_REG_OFFSET, 32'h0000_000C);
      @(negedge clk);
      {fundamental_reset_n, global_reset_n} = k ? 2'b10 : 2'b01;
      @(negedge clk);
      {fundamental_reset_n, global_reset_n} = 2'b11;
      `CHK("rst ptr", 5'h00, first_error_pointer)
      acc(0, `SEV_REG_OFFSET, '0);
      `CHK("rst sev", 32'h0000_0040, rd_q)
    end
    end_of_test();
  end
endmodule
